/* File: rtl/umcls_defs.svh */
`ifndef UMCLS_DEFS_SVH
`define UMCLS_DEFS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define UMCLS_ADDR_DATA 32'hffff0800
`define UMCLS_ADDR_CTRL 32'hffff0810
`define UMCLS_ADDR_STATUS 32'hffff0814
`define UMCLS_ADDR_INT_STATUS 32'hffff0818
`define UMCLS_ADDR_INT_MASK 32'hffff081c

// ****************************************
// Field positions and masks
// ****************************************
`define UMCLS_CTRL_LOOPBACK 4
`define UMCLS_CTRL_RTS 1
`define UMCLS_CTRL_DTR 0
`define UMCLS_CTRL_WMASK 8'h13
`define UMCLS_INT_RX 0
`define UMCLS_INT_TX 1
`define UMCLS_INT_LINE 2
`define UMCLS_INT_W 3

// ****************************************
// Reset values
// ****************************************
`define UMCLS_CTRL_RESET 8'h00
`define UMCLS_STATUS_RESET 8'h60
`define UMCLS_INT_RESET 3'h0

// ****************************************
// Timing
// ****************************************
`define UMCLS_BAUD_DIV_DEFAULT 16
`define UMCLS_MAX_FRAME_BITS 12

`endif

/* File: rtl/umcls_pkg.sv */
package umcls_pkg;

  typedef enum logic [1:0] {WL5, WL6, WL7, WL8} umcls_wlen_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} umcls_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} umcls_rx_state_t;

endpackage : umcls_pkg

/* File: rtl/umcls_top.sv */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`include "umcls_defs.svh"

module umcls_top #(
  parameter int BAUD_DIV = `UMCLS_BAUD_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire umcls_pkg::umcls_wlen_t frameWordLen,
  input wire logic frameParityEn,
  input wire logic frameEvenParity,
  input wire logic frameStickParity,
  input wire logic frameTwoStop,
  input wire logic frameSetBreak,
  input wire logic serialInPin,
  output logic serialOutPin,
  output logic rtsN,
  output logic dtrN,
  output logic irq
);
  import umcls_pkg::*;

  localparam logic [15:0] BIT_CYC = 16'(BAUD_DIV);
  localparam logic [15:0] HALF_CYC = 16'(BAUD_DIV / 2);
  localparam logic [23:0] BREAK_CYC = 24'(BAUD_DIV * `UMCLS_MAX_FRAME_BITS);

  function automatic logic [3:0] wordBits(umcls_wlen_t wl);
    return 4'd5 + 4'(wl);
  endfunction : wordBits

  function automatic logic parityBit(logic [7:0] data, umcls_wlen_t wl, logic even, logic stick);
    logic [7:0] d;
    d = data & (8'hff >> (4'd8 - wordBits(wl)));
    if (stick)
      return even;
    return even ? ^d : ~^d;
  endfunction : parityBit

  function automatic logic [15:0] stopCycles(umcls_wlen_t wl, logic two);
    if (!two)
      return BIT_CYC;
    return (wl == WL5) ? 16'(BIT_CYC + HALF_CYC) : 16'(BIT_CYC * 2);
  endfunction : stopCycles

  // ****************************************
  // APB slave
  // ****************************************
  logic pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q;
  logic [31:0] rdData;
  logic hit;
  logic done, wrDone, rdDone;
  logic [7:0] ctrl_q;
  logic [7:0] thr_q, rbr_q;
  logic thrFull_q;
  logic dr_q, oe_q, pe_q, fe_q, bi_q;
  logic [`UMCLS_INT_W-1:0] intStat_q, intMask_q;
  umcls_tx_state_t txState_q;
  logic tx_all_empty, tx_holding_empty;

  assign done = psel & penable & pready_q;
  assign wrDone = done & pwrite;
  assign rdDone = done & ~pwrite;
  assign tx_holding_empty = ~thrFull_q;
  assign tx_all_empty = ~thrFull_q & (txState_q == TX_IDLE);

  always_comb
  begin
    hit = 1'b1;
    rdData = 32'h0;
    if (paddr == `UMCLS_ADDR_DATA)
      rdData = {24'h0, rbr_q};
    else if (paddr == `UMCLS_ADDR_CTRL)
      rdData = {24'h0, ctrl_q};
    else if (paddr == `UMCLS_ADDR_STATUS)
      rdData = {24'h0, 1'b0, tx_all_empty, tx_holding_empty, bi_q, fe_q, pe_q, oe_q, dr_q};
    else if (paddr == `UMCLS_ADDR_INT_STATUS)
      rdData = {29'h0, intStat_q};
    else if (paddr == `UMCLS_ADDR_INT_MASK)
      rdData = {29'h0, intMask_q};
    else
      hit = 1'b0;
  end

  // One wait state: answer on the second access cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~hit;
      prdata_q <= (psel & penable & ~pready_q & ~pwrite) ? rdData : 32'h0;
    end
  end

  wire wrData = wrDone & (paddr == `UMCLS_ADDR_DATA);
  wire rdData0 = rdDone & (paddr == `UMCLS_ADDR_DATA);
  wire rdStatus = rdDone & (paddr == `UMCLS_ADDR_STATUS);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q <= `UMCLS_CTRL_RESET;
      intMask_q <= `UMCLS_INT_RESET;
    end
    else if (wrDone && paddr == `UMCLS_ADDR_CTRL)
      ctrl_q <= pwdata[7:0] & `UMCLS_CTRL_WMASK;
    else if (wrDone && paddr == `UMCLS_ADDR_INT_MASK)
      intMask_q <= pwdata[`UMCLS_INT_W-1:0];
  end

  // ****************************************
  // Transmitter
  // ****************************************
  logic [15:0] txCnt_q;
  logic [3:0] txIdx_q;
  logic [7:0] txData_q;
  logic txBit_q;
  logic txLoad;

  assign txLoad = (txState_q == TX_IDLE) & thrFull_q;

  // Holding register accepts writes while the shifter is still busy
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      thr_q <= 8'h00;
      thrFull_q <= 1'b0;
    end
    else if (wrData)
    begin
      thr_q <= pwdata[7:0];
      thrFull_q <= 1'b1;
    end
    else if (txLoad)
      thrFull_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txState_q <= TX_IDLE;
      txCnt_q <= 16'h0;
      txIdx_q <= 4'h0;
      txData_q <= 8'h00;
      txBit_q <= 1'b1;
    end
    else
    begin
      txCnt_q <= txCnt_q - 16'h1;
      case (txState_q)
        TX_IDLE:
        begin
          txBit_q <= 1'b1;
          if (thrFull_q)
          begin
            txData_q <= thr_q;
            txBit_q <= 1'b0;
            txCnt_q <= BIT_CYC - 16'h1;
            txState_q <= TX_START;
          end
        end
        TX_START:
          if (txCnt_q == 16'h0)
          begin
            txBit_q <= txData_q[0];
            txIdx_q <= 4'h1;
            txCnt_q <= BIT_CYC - 16'h1;
            txState_q <= TX_DATA;
          end
        TX_DATA:
          if (txCnt_q == 16'h0)
          begin
            txCnt_q <= BIT_CYC - 16'h1;
            if (txIdx_q == wordBits(frameWordLen))
            begin
              if (frameParityEn)
              begin
                txBit_q <= parityBit(txData_q, frameWordLen, frameEvenParity, frameStickParity);
                txState_q <= TX_PAR;
              end
              else
              begin
                txBit_q <= 1'b1;
                txCnt_q <= stopCycles(frameWordLen, frameTwoStop) - 16'h1;
                txState_q <= TX_STOP;
              end
            end
            else
            begin
              txBit_q <= txData_q[txIdx_q[2:0]];
              txIdx_q <= txIdx_q + 4'h1;
            end
          end
        TX_PAR:
          if (txCnt_q == 16'h0)
          begin
            txBit_q <= 1'b1;
            txCnt_q <= stopCycles(frameWordLen, frameTwoStop) - 16'h1;
            txState_q <= TX_STOP;
          end
        TX_STOP:
          if (txCnt_q == 16'h0)
            txState_q <= TX_IDLE;
        default:
          txState_q <= TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  umcls_rx_state_t rxState_q;
  logic [15:0] rxCnt_q;
  logic [3:0] rxIdx_q;
  logic [7:0] rxSh_q;
  logic rxParBad_q, rxPrev_q;
  logic [23:0] lowCnt_q;
  logic rxIn, rxDone, brkEv;

  // Loopback feeds the receiver from the internal transmit line
  assign rxIn = ctrl_q[`UMCLS_CTRL_LOOPBACK] ? txBit_q : serialInPin;
  assign rxDone = (rxState_q == RX_STOP) & (rxCnt_q == 16'h0);
  assign brkEv = ~rxIn & (lowCnt_q == BREAK_CYC);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxState_q <= RX_IDLE;
      rxCnt_q <= 16'h0;
      rxIdx_q <= 4'h0;
      rxSh_q <= 8'h00;
      rxParBad_q <= 1'b0;
      rxPrev_q <= 1'b1;
    end
    else
    begin
      rxPrev_q <= rxIn;
      rxCnt_q <= rxCnt_q - 16'h1;
      case (rxState_q)
        RX_IDLE:
          if (rxPrev_q && !rxIn)
          begin
            rxCnt_q <= HALF_CYC - 16'h1;
            rxState_q <= RX_START;
          end
        RX_START:
          if (rxCnt_q == 16'h0)
          begin
            rxSh_q <= 8'h00;
            rxParBad_q <= 1'b0;
            rxIdx_q <= 4'h0;
            rxCnt_q <= BIT_CYC - 16'h1;
            rxState_q <= rxIn ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rxCnt_q == 16'h0)
          begin
            rxSh_q[rxIdx_q[2:0]] <= rxIn;
            rxIdx_q <= rxIdx_q + 4'h1;
            rxCnt_q <= BIT_CYC - 16'h1;
            if (rxIdx_q == wordBits(frameWordLen) - 4'h1)
              rxState_q <= frameParityEn ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (rxCnt_q == 16'h0)
          begin
            rxParBad_q <= rxIn != parityBit(rxSh_q, frameWordLen, frameEvenParity, frameStickParity);
            rxCnt_q <= BIT_CYC - 16'h1;
            rxState_q <= RX_STOP;
          end
        RX_STOP:
          if (rxCnt_q == 16'h0)
            rxState_q <= RX_IDLE;
        default:
          rxState_q <= RX_IDLE;
      endcase
    end
  end

  // Saturates one past the threshold so a long break flags once
  always_ff @(posedge clk)
  begin
    if (rst || rxIn)
      lowCnt_q <= 24'h0;
    else if (lowCnt_q <= BREAK_CYC)
      lowCnt_q <= lowCnt_q + 24'h1;
  end

  // ****************************************
  // Line status flags, set wins over clear
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rbr_q <= 8'h00;
      dr_q <= 1'b0;
    end
    else if (rxDone)
    begin
      rbr_q <= rxSh_q;
      dr_q <= 1'b1;
    end
    else if (rdData0)
      dr_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      oe_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      bi_q <= 1'b0;
    end
    else
    begin
      oe_q <= (rxDone & dr_q & ~rdData0) | (oe_q & ~rdStatus);
      pe_q <= (rxDone & frameParityEn & rxParBad_q) | (pe_q & ~rdStatus);
      fe_q <= (rxDone & ~rxIn) | (fe_q & ~rdStatus);
      bi_q <= brkEv | (bi_q & ~rdStatus);
    end
  end

  // ****************************************
  // Interrupt status, write one to clear
  // ****************************************
  logic [`UMCLS_INT_W-1:0] intEv, intClr;

  assign intEv = {brkEv | (rxDone & (~rxIn | (frameParityEn & rxParBad_q) | (dr_q & ~rdData0))), txLoad, rxDone};
  assign intClr = (wrDone && paddr == `UMCLS_ADDR_INT_STATUS) ? pwdata[`UMCLS_INT_W-1:0] : `UMCLS_INT_RESET;

  always_ff @(posedge clk)
  begin
    if (rst)
      intStat_q <= `UMCLS_INT_RESET;
    else
      intStat_q <= (intStat_q & ~intClr) | intEv;
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  logic serialOut_q, rtsN_q, dtrN_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serialOut_q <= 1'b1;
      rtsN_q <= 1'b1;
      dtrN_q <= 1'b1;
      irq_q <= 1'b0;
    end
    else
    begin
      // Loopback takes precedence over a forced break
      serialOut_q <= ctrl_q[`UMCLS_CTRL_LOOPBACK] | (~frameSetBreak & txBit_q);
      rtsN_q <= ~ctrl_q[`UMCLS_CTRL_RTS];
      dtrN_q <= ~ctrl_q[`UMCLS_CTRL_DTR];
      irq_q <= |(intStat_q & intMask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serialOutPin = serialOut_q;
  assign rtsN = rtsN_q;
  assign dtrN = dtrN_q;
  assign irq = irq_q;

endmodule : umcls_top

/* File: sim/umcls_peer.sv */
`timescale 1ns/1ns
module umcls_peer #(
  parameter int BAUD_DIV = 4
) (
  input wire logic clk,
  input wire logic serialOutPin,
  output logic serialInPin
);
  logic [7:0] rxByte;
  int rxCount = 0;
  initial serialInPin = 1'b1;
  // Sends n bits LSB first, then back to mark; bits past f are low (break)
  task automatic bits(input logic [10:0] f, input int n);
    repeat (n)
    begin
      serialInPin <= f[0];
      f = f >> 1;
      repeat (BAUD_DIV) @(posedge clk);
    end
    serialInPin <= 1'b1;
    // One idle edge so back-to-back frames never assign the pin twice at once
    @(posedge clk);
  endtask : bits
  // Fixed 8 data bits plus parity; neither parity nor stop bit checked here
  always
  begin
    @(negedge serialOutPin);
    repeat (BAUD_DIV / 2) @(posedge clk);
    repeat (8)
    begin
      repeat (BAUD_DIV) @(posedge clk);
      rxByte = {serialOutPin, rxByte[7:1]};
    end
    repeat (2 * BAUD_DIV) @(posedge clk);
    rxCount++;
  end
endmodule : umcls_peer

/* File: sim/umcls_sva.sv */
`timescale 1ns/1ns
`include "umcls_defs.svh"
module umcls_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serialOutPin,
  input wire logic rtsN,
  input wire logic dtrN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic done;
  logic mapped;
  assign done = psel && penable && pready;
  assign mapped = paddr inside {`UMCLS_ADDR_DATA, `UMCLS_ADDR_CTRL, `UMCLS_ADDR_STATUS,
    `UMCLS_ADDR_INT_STATUS, `UMCLS_ADDR_INT_MASK};
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  sequence s_ctl_wr;
    done && pwrite && paddr == `UMCLS_ADDR_CTRL;
  endsequence
  chk_one_wait: assert property (s_setup |=> s_answer) else $error("pready not in second access cycle");
  chk_rts_level: assert property (s_ctl_wr |-> ##2 rtsN == !$past(pwdata[1], 2))
    else $error("rtsN does not follow control bit 1");
  chk_dtr_level: assert property (s_ctl_wr |-> ##2 dtrN == !$past(pwdata[0], 2))
    else $error("dtrN does not follow control bit 0");
  chk_loop_high: assert property (s_ctl_wr and pwdata[4] |-> ##2 serialOutPin [*3])
    else $error("serial output low in loopback");
  chk_ctl_rsvd: assert property (done && !pwrite && paddr == `UMCLS_ADDR_CTRL |-> (prdata & ~32'h13) == 0)
    else $error("reserved control bits not zero");
  chk_sta_rsvd: assert property (done && !pwrite && paddr == `UMCLS_ADDR_STATUS |-> prdata[31:7] == 0)
    else $error("status bit 7 not zero");
  chk_bad_addr: assert property (done && !mapped |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  chk_err_pair: assert property (pslverr |-> pready && !mapped) else $error("pslverr outside answer");
  chk_idle_data: assert property (!pready |-> prdata == 0) else $error("read data outside answer");
endmodule : umcls_sva
bind umcls_top umcls_sva i_sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serialOutPin(serialOutPin), .rtsN(rtsN), .dtrN(dtrN));

/* File: sim/umcls_tb.sv */
`timescale 1ns/1ns
`include "umcls_defs.svh"
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module testbench;
  import umcls_pkg::*;
  localparam int BD = 4;
  logic clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, ev;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rv;
  logic frameSetBreak = 1'b0, serialInPin, serialOutPin, rtsN, dtrN;
  logic [7:0] b, c;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, seed = 32'h5651;
  umcls_top #(.BAUD_DIV(BD)) i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frameWordLen(WL8),
    .frameParityEn(1'b1), .frameEvenParity(1'b1), .frameStickParity(1'b0), .frameTwoStop(1'b0),
    .frameSetBreak(frameSetBreak), .serialInPin(serialInPin), .serialOutPin(serialOutPin), .rtsN(rtsN),
    .dtrN(dtrN), .irq(irq));
  umcls_peer #(.BAUD_DIV(BD)) i_peer (.clk(clk), .serialOutPin(serialOutPin), .serialInPin(serialInPin));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****
  // Helpers
  // ****
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  function automatic logic [31:0] staExp(input logic dr, oe, pe, fe, bi);
    return {24'h0, 3'b011, bi, fe, pe, oe, dr};
  endfunction : staExp
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Look at pready mid-cycle so the answer is seen settled, then finish at the edge
    do
    begin
      @(negedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rv = prdata;
    ev = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) n_mismatch++;
  endtask : apb
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1, `UMCLS_ADDR_STATUS, 32'hff);
    apb(0, `UMCLS_ADDR_STATUS, 0);
    `CHK("status rst", 32'h60, rv)
    apb(0, `UMCLS_ADDR_CTRL, 0);
    `CHK("ctrl rst", 32'h0, rv)
    apb(0, 32'hffff0820, 0);
    `CHK("bad addr", 1'b1, ev)
    for (int i = 0; i < 8; i++)
    begin
      c = (i == 0) ? 8'hff : 8'($random(seed));
      apb(1, `UMCLS_ADDR_CTRL, {24'h0, c});
      apb(0, `UMCLS_ADDR_CTRL, 0);
      `CHK("ctrl", {24'h0, c & `UMCLS_CTRL_WMASK}, rv)
      `CHK("rtsN", !c[1], rtsN)
      `CHK("dtrN", !c[0], dtrN)
    end
    apb(1, `UMCLS_ADDR_CTRL, 0);
    b = 8'($random(seed));
    c = 8'($random(seed));
    apb(1, `UMCLS_ADDR_DATA, {24'h0, b});
    apb(1, `UMCLS_ADDR_DATA, {24'h0, c});
    apb(0, `UMCLS_ADDR_STATUS, 0);
    `CHK("tx full", 32'h0, rv & 32'h60)
    for (int i = 0; i < 200 && rv[6] !== 1'b1; i++) apb(0, `UMCLS_ADDR_STATUS, 0);
    `CHK("tx empty", 32'h60, rv & 32'h60)
    `CHK("peer byte", c, i_peer.rxByte)
    `CHK("peer count", 2, i_peer.rxCount)
    // Good, bad parity, bad stop, overrun, break
    for (int k = 0; k < 5; k++)
    begin
      b = 8'($random(seed));
      if (k == 4) i_peer.bits(11'h0, 14);
      else repeat (k == 3 ? 2 : 1) i_peer.bits({k != 2, ^b ^ (k == 1), b, 1'b0}, 11);
      repeat (4) @(posedge clk);
      apb(0, `UMCLS_ADDR_STATUS, 0);
      `CHK("rx status", staExp(1, k == 3, k == 1, k == 2 || k == 4, k == 4), rv)
      apb(0, `UMCLS_ADDR_DATA, 0);
      `CHK("rx data", {24'h0, k == 4 ? 8'h0 : b}, rv)
      apb(0, `UMCLS_ADDR_STATUS, 0);
      `CHK("rx cleared", 32'h60, rv)
    end
    apb(1, `UMCLS_ADDR_INT_STATUS, 32'h7);
    apb(1, `UMCLS_ADDR_INT_MASK, 32'h0);
    i_peer.bits({1'b1, ^b, b, 1'b0}, 11);
    repeat (4) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    apb(0, `UMCLS_ADDR_INT_STATUS, 0);
    `CHK("int status", 32'h1, rv)
    apb(1, `UMCLS_ADDR_INT_MASK, 32'h1);
    apb(0, `UMCLS_ADDR_INT_MASK, 0);
    `CHK("irq on", 1'b1, irq)
    apb(1, `UMCLS_ADDR_INT_STATUS, 32'h1);
    apb(0, `UMCLS_ADDR_DATA, 0);
    `CHK("irq off", 1'b0, irq)
    frameSetBreak <= 1'b1;
    apb(1, `UMCLS_ADDR_CTRL, 32'h10);
    apb(0, `UMCLS_ADDR_CTRL, 0);
    `CHK("loop out", 1'b1, serialOutPin)
    apb(1, `UMCLS_ADDR_CTRL, 32'h0);
    apb(0, `UMCLS_ADDR_CTRL, 0);
    `CHK("break out", 1'b0, serialOutPin)
    stop_test();
  end
endmodule : testbench
